/* File: smb_consts.svh */
// constants shared by both ends of the serial management link
`ifndef SMB_CONSTS_SVH
`define SMB_CONSTS_SVH
`define ADDR_HI 4'h5
`define ARA_ADDR 7'h0c
`define BLK_LEN_OFS 7'h00
`define CFG_ONE_OFS 7'h01
`define CFG_SDA_TO_BIT 5
`define CFG_SCL_TO_BIT 4
`define BLK_LEN_RST 8'h00
`define CFG_ONE_RST 8'h00
`define BLK_MAX 8'h20
`define RAM_END 7'h40
`define RAM_DEPTH 64
`define TEMP_PAGE 5'h10
`define CRC_POLY 8'h07
`define TOUT_MS 25
`define MCLK_KHZ 20000
`define SCL_QTR 4'h8
`define HREG_CMD 4'h0
`define HREG_STAT 4'h4
`define HCMD_OP_LSB 8
`define HCMD_NACK_BIT 10
`endif

/* File: smb_pkg.sv */
// types shared by both ends of the serial management link
package smb_pkg;
    typedef enum logic [2:0] {T_IDLE, T_RX, T_RXACK, T_TX, T_TXACK} tgt_state_e;
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} host_op_e;
endpackage

/* File: smb_if.sv */
// open-drain clock, data and alert lines joining host and target
`timescale 1ns/1ps
interface smb_if;
    logic scl_h_o;
    logic scl_h_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic alert_d_o;
    logic alert_d_oe;
    logic scl;
    logic sda;
    logic alert;
    // wired-and with pull-ups
    assign scl = !(scl_h_oe && !scl_h_o);
    assign sda = !(sda_h_oe && !sda_h_o) && !(sda_d_oe && !sda_d_o);
    assign alert = !(alert_d_oe && !alert_d_o);
    modport device(input scl, input sda, output sda_d_o, output sda_d_oe, output alert_d_o, output alert_d_oe);
    modport host(input sda, input alert, output scl_h_o, output scl_h_oe, output sda_h_o, output sda_h_oe);
endinterface

/* File: smb_target.sv */
// target end: address match, register pointer, block transfers, pec, alert response, temperature lock
// Contract
// - address byte msb first, answer own address
// - bus address fixed from strap at power-up
// - first write byte loads pointer, msb selects block
// - block write carries at most 32 bytes; the code takes the count byte unchecked, up to 255
// - acknowledge pointer, count and each data byte
// - receive byte returns byte at pointer
// - host nacks receive byte then stops
// - host sets read length at offset zero first
// - block read never exceeds 32 data bytes
// - block read returns count then data
// - host acks all but last, then stops
// - optional inactivity timeout releases bus, off at reset
// - config one bit five enables data timeout
// - config one bit four enables clock timeout
// - extra byte is crc-8 packet error check
// - host reads alert response address when alerted
// - alerting device returns own address to ara
// - arbitration lets lowest address win alert response
// - release alert after answering, reassert if persisting
// - temperatures are 13-bit, split high and low
// - low byte read freezes result until high read
// - high byte read alone does not freeze
// - fan logic keeps getting fresh temperatures
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "smb_consts.svh"
module smb_target
    import smb_pkg::*;
#(
    parameter int TIMEOUT_CYC = `TOUT_MS * `MCLK_KHZ
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] address_select_input,
    input wire logic [12:0] local_temp,
    input wire logic [12:0] remote_temp,
    input wire logic temp_update,
    input wire logic fault,
    input wire logic monitor_tick,
    output logic [12:0] fan_local_temp,
    output logic [12:0] fan_remote_temp,
    smb_if.device bus
);
    // ==========================================================
    // line synchronisers, bit 0 clock, bit 1 data
    logic [1:0] s1_ff, s2_ff, s3_ff, line_ff, prev_ff;
    logic [1:0] raw;
    assign raw = {bus.sda, bus.scl};
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                s1_ff[i] <= 1'b1;
                s2_ff[i] <= 1'b1;
                s3_ff[i] <= 1'b1;
                line_ff[i] <= 1'b1;
                prev_ff[i] <= 1'b1;
            end
            else
            begin
                s1_ff[i] <= raw[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                if (s2_ff[i] == s3_ff[i])
                    line_ff[i] <= s3_ff[i];
                prev_ff[i] <= line_ff[i];
            end
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c, sda;
    assign sda = line_ff[1];
    assign scl_rise = line_ff[0] && !prev_ff[0];
    assign scl_fall = !line_ff[0] && prev_ff[0];
    assign start_c = line_ff[0] && prev_ff[0] && prev_ff[1] && !line_ff[1];
    assign stop_c = line_ff[0] && prev_ff[0] && !prev_ff[1] && line_ff[1];

    // ==========================================================
    // address strap, caught once after reset release
    logic strap_done_ff;
    logic [6:0] own_ff;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strap_done_ff <= 1'b0;
            own_ff <= 7'h00;
        end
        else if (!strap_done_ff)
        begin
            own_ff <= {`ADDR_HI, address_select_input};
            strap_done_ff <= 1'b1;
        end
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
        return r;
    endfunction

    // ==========================================================
    // transfer state
    tgt_state_e st_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff, idx_ff, tx_idx_ff, cnt_ff, crc_ff;
    logic [6:0] ptr_ff, wr_adr_ff;
    logic [7:0] wr_dat_ff, blk_len_ff, cfg_one_ff, rd_data, nxt_tx, eff_len;
    logic rd_ff, ara_ff, blk_ff, drv_ff, acked_ff, wr_ff, alert_ff, to_hit;
    logic [7:0] ram [`RAM_DEPTH];
    logic [12:0] shadow_ff [2];
    logic [12:0] temp_in [2];
    logic lock_ff [2];
    logic rx_ack, pec_byte, rx_store, tx_load, incr, from_reg, ara_done;

    assign eff_len = (blk_len_ff > `BLK_MAX) ? `BLK_MAX : blk_len_ff;
    assign tx_load = scl_fall && ((st_ff == T_RXACK && rd_ff) || (st_ff == T_TXACK && acked_ff));
    assign ara_done = st_ff == T_TXACK && scl_rise && ara_ff && tx_idx_ff == 8'h01;

    always_comb
    begin
        case (ptr_ff)
            `BLK_LEN_OFS: rd_data = blk_len_ff;
            `CFG_ONE_OFS: rd_data = cfg_one_ff;
            // low byte holds the five fraction bits at the top
            {`TEMP_PAGE, 2'h0}: rd_data = {shadow_ff[0][4:0], 3'h0};
            {`TEMP_PAGE, 2'h1}: rd_data = shadow_ff[0][12:5];
            {`TEMP_PAGE, 2'h2}: rd_data = {shadow_ff[1][4:0], 3'h0};
            {`TEMP_PAGE, 2'h3}: rd_data = shadow_ff[1][12:5];
            default: rd_data = (ptr_ff < `RAM_END) ? ram[ptr_ff[5:0]] : 8'h00;
        endcase
    end

    always_comb
    begin
        incr = 1'b0;
        from_reg = 1'b0;
        if (ara_ff)
            nxt_tx = (tx_idx_ff == 8'h00) ? {own_ff, 1'b0} : crc_ff;
        else if (blk_ff)
        begin
            if (tx_idx_ff == 8'h00)
                nxt_tx = eff_len;
            else if (tx_idx_ff <= eff_len)
            begin
                nxt_tx = rd_data;
                incr = 1'b1;
                from_reg = 1'b1;
            end
            else
                nxt_tx = crc_ff;
        end
        else
        begin
            nxt_tx = (tx_idx_ff == 8'h00) ? rd_data : crc_ff;
            from_reg = tx_idx_ff == 8'h00;
        end
    end

    always_comb
    begin
        pec_byte = blk_ff ? ({1'b0, idx_ff} >= {1'b0, cnt_ff} + 9'h003) : (idx_ff >= 8'h03);
        rx_store = idx_ff >= 8'h02 && !pec_byte && !(blk_ff && idx_ff == 8'h02);
        if (idx_ff == 8'h00)
            rx_ack = sh_ff[7:1] == own_ff || (sh_ff[7:1] == `ARA_ADDR && sh_ff[0] && alert_ff);
        else if (idx_ff >= 8'h02 && pec_byte)
            rx_ack = sh_ff == crc_ff;
        else
            rx_ack = 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= T_IDLE;
            bit_ff <= 4'h0;
            sh_ff <= 8'h00;
            idx_ff <= 8'h00;
            tx_idx_ff <= 8'h00;
            cnt_ff <= 8'h00;
            crc_ff <= 8'h00;
            ptr_ff <= 7'h00;
            rd_ff <= 1'b0;
            ara_ff <= 1'b0;
            blk_ff <= 1'b0;
            drv_ff <= 1'b0;
            acked_ff <= 1'b0;
            wr_ff <= 1'b0;
            wr_adr_ff <= 7'h00;
            wr_dat_ff <= 8'h00;
        end
        else
        begin
            wr_ff <= 1'b0;
            if (to_hit || stop_c)
            begin
                st_ff <= T_IDLE;
                drv_ff <= 1'b0;
            end
            else if (start_c)
            begin
                // a repeated start keeps the running check value
                if (st_ff == T_IDLE)
                    crc_ff <= 8'h00;
                st_ff <= T_RX;
                bit_ff <= 4'h0;
                idx_ff <= 8'h00;
                drv_ff <= 1'b0;
            end
            else if (tx_load)
            begin
                st_ff <= T_TX;
                sh_ff <= nxt_tx;
                drv_ff <= !nxt_tx[7];
                bit_ff <= 4'h0;
                crc_ff <= crc8(crc_ff, nxt_tx);
                tx_idx_ff <= tx_idx_ff + 8'h01;
                if (incr)
                    ptr_ff <= ptr_ff + 7'h01;
            end
            else
            begin
                case (st_ff)
                    T_RX:
                    begin
                        if (scl_rise && bit_ff != 4'h8)
                        begin
                            sh_ff <= {sh_ff[6:0], sda};
                            bit_ff <= bit_ff + 4'h1;
                        end
                        else if (scl_fall && bit_ff == 4'h8)
                        begin
                            crc_ff <= crc8(crc_ff, sh_ff);
                            idx_ff <= idx_ff + 8'h01;
                            st_ff <= rx_ack ? T_RXACK : T_IDLE;
                            drv_ff <= rx_ack;
                            if (idx_ff == 8'h00)
                            begin
                                rd_ff <= sh_ff[0];
                                ara_ff <= sh_ff[7:1] == `ARA_ADDR;
                                tx_idx_ff <= 8'h00;
                            end
                            if (idx_ff == 8'h01)
                            begin
                                ptr_ff <= sh_ff[6:0];
                                blk_ff <= sh_ff[7];
                            end
                            if (idx_ff == 8'h02 && blk_ff)
                                cnt_ff <= sh_ff;
                            if (rx_store)
                            begin
                                wr_ff <= 1'b1;
                                wr_adr_ff <= ptr_ff;
                                wr_dat_ff <= sh_ff;
                                if (blk_ff)
                                    ptr_ff <= ptr_ff + 7'h01;
                            end
                        end
                    end
                    T_RXACK:
                    begin
                        if (scl_fall)
                        begin
                            drv_ff <= 1'b0;
                            st_ff <= T_RX;
                            bit_ff <= 4'h0;
                        end
                    end
                    T_TX:
                    begin
                        if (scl_rise && !drv_ff && !sda)
                            st_ff <= T_IDLE;
                        else if (scl_fall && bit_ff == 4'h7)
                        begin
                            drv_ff <= 1'b0;
                            st_ff <= T_TXACK;
                        end
                        else if (scl_fall)
                        begin
                            bit_ff <= bit_ff + 4'h1;
                            sh_ff <= {sh_ff[6:0], 1'b0};
                            drv_ff <= !sh_ff[6];
                        end
                    end
                    T_TXACK:
                    begin
                        if (scl_rise)
                        begin
                            acked_ff <= !sda;
                            if (sda)
                                st_ff <= T_IDLE;
                        end
                    end
                    default: st_ff <= T_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // register storage; configuration and length reset, the rest need not
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            blk_len_ff <= `BLK_LEN_RST;
            cfg_one_ff <= `CFG_ONE_RST;
        end
        else if (wr_ff && wr_adr_ff == `BLK_LEN_OFS)
            blk_len_ff <= wr_dat_ff;
        else if (wr_ff && wr_adr_ff == `CFG_ONE_OFS)
            cfg_one_ff <= wr_dat_ff;
    end

    always_ff @(posedge mclk)
    begin
        if (wr_ff && wr_adr_ff < `RAM_END)
            ram[wr_adr_ff[5:0]] <= wr_dat_ff;
    end

    // ==========================================================
    // inactivity timeout: counts while an enabled line is held low
    logic [19:0] to_cnt_ff;
    logic to_arm;
    assign to_arm = st_ff != T_IDLE && ((cfg_one_ff[`CFG_SCL_TO_BIT] && !line_ff[0])
        || (cfg_one_ff[`CFG_SDA_TO_BIT] && !line_ff[1]));
    assign to_hit = to_cnt_ff == 20'(TIMEOUT_CYC - 1);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            to_cnt_ff <= 20'h00000;
        else if (!to_arm || line_ff != prev_ff || to_hit)
            to_cnt_ff <= 20'h00000;
        else
            to_cnt_ff <= to_cnt_ff + 20'h00001;
    end

    // ==========================================================
    // temperature results and lock
    assign temp_in[0] = local_temp;
    assign temp_in[1] = remote_temp;
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_temp
        logic hit;
        assign hit = tx_load && from_reg && !ara_ff && ptr_ff[6:2] == `TEMP_PAGE && ptr_ff[1] == 1'(ch);
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
                lock_ff[ch] <= 1'b0;
            else if (hit)
                lock_ff[ch] <= !ptr_ff[0];
        end
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
                shadow_ff[ch] <= 13'h0000;
            else if (temp_update && !lock_ff[ch] && !(hit && !ptr_ff[0]))
                shadow_ff[ch] <= temp_in[ch];
        end
    end

    // lock never gates the fan path
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fan_local_temp <= 13'h0000;
            fan_remote_temp <= 13'h0000;
        end
        else if (temp_update)
        begin
            fan_local_temp <= local_temp;
            fan_remote_temp <= remote_temp;
        end
    end

    // ==========================================================
    // alert: a monitoring tick with fault set beats the clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            alert_ff <= 1'b0;
        else if (monitor_tick && fault)
            alert_ff <= 1'b1;
        else if (ara_done)
            alert_ff <= 1'b0;
    end

    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = drv_ff;
    assign bus.alert_d_o = 1'b0;
    assign bus.alert_d_oe = alert_ff;
endmodule

/* File: smb_host.sv */
// host end: avalon-mm command port driving start, stop and byte transfers
`timescale 1ns/1ps
`include "smb_consts.svh"
module smb_host
    import smb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    smb_if.host bus
);
    // ==========================================================
    // input synchronisers, bit 0 data, bit 1 alert
    logic [1:0] s1_ff, s2_ff, s3_ff, line_ff, raw;
    assign raw = {bus.alert, bus.sda};
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                s1_ff[i] <= 1'b1;
                s2_ff[i] <= 1'b1;
                s3_ff[i] <= 1'b1;
                line_ff[i] <= 1'b1;
            end
            else
            begin
                s1_ff[i] <= raw[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                if (s2_ff[i] == s3_ff[i])
                    line_ff[i] <= s3_ff[i];
            end
        end
    end

    // ==========================================================
    // bus slave
    logic busy_ff, rd_done_ff, take;
    logic [7:0] rx_ff, tx_ff;
    logic ack_ff, nack_ff;
    assign take = avs_write && avs_address == `HREG_CMD && !busy_ff;
    // commands stall while a transfer runs; reads answer one cycle late
    assign avs_waitrequest = (avs_write && avs_address == `HREG_CMD && busy_ff) || (avs_read && !rd_done_ff);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_done_ff <= 1'b0;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            rd_done_ff <= avs_read && !rd_done_ff;
            if (avs_read && !rd_done_ff)
                avs_readdata <= (avs_address == `HREG_STAT) ?
                    {21'h000000, !line_ff[1], ack_ff, busy_ff, rx_ff} : 32'h00000000;
        end
    end

    // ==========================================================
    // line engine: four quarter phases per start, stop or bit
    host_op_e op_ff;
    logic [3:0] q_ff, bit_ff;
    logic [1:0] ph_ff;
    logic scl_low_ff, sda_low_ff, tick, bitval, is_bit;
    assign tick = busy_ff && q_ff == `SCL_QTR - 4'h1;
    assign is_bit = op_ff == OP_WRITE || op_ff == OP_READ;
    // ninth bit: released on write to hear ack, on read driven low to ack or released to nack
    assign bitval = (op_ff == OP_WRITE) ? (bit_ff == 4'h8 || tx_ff[3'(4'h7 - bit_ff)])
        : (bit_ff != 4'h8 || nack_ff);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            busy_ff <= 1'b0;
            op_ff <= OP_START;
            q_ff <= 4'h0;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            tx_ff <= 8'h00;
            nack_ff <= 1'b0;
            rx_ff <= 8'h00;
            ack_ff <= 1'b0;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
        end
        else if (take)
        begin
            busy_ff <= 1'b1;
            op_ff <= host_op_e'(avs_writedata[`HCMD_OP_LSB +: 2]);
            tx_ff <= avs_writedata[7:0];
            nack_ff <= avs_writedata[`HCMD_NACK_BIT];
            q_ff <= 4'h0;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            scl_low_ff <= 1'b1;
        end
        else if (tick)
        begin
            q_ff <= 4'h0;
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
                2'h0: sda_low_ff <= (op_ff == OP_START) ? 1'b0 : (op_ff == OP_STOP) ? 1'b1 : !bitval;
                2'h1: scl_low_ff <= 1'b0;
                2'h2:
                begin
                    if (op_ff == OP_START)
                        sda_low_ff <= 1'b1;
                    else if (op_ff == OP_STOP)
                        sda_low_ff <= 1'b0;
                    else if (bit_ff == 4'h8)
                        ack_ff <= !line_ff[0];
                    else
                        rx_ff <= {rx_ff[6:0], line_ff[0]};
                end
                default:
                begin
                    if (is_bit && bit_ff != 4'h8)
                    begin
                        bit_ff <= bit_ff + 4'h1;
                        scl_low_ff <= 1'b1;
                    end
                    else
                        busy_ff <= 1'b0;
                end
            endcase
        end
        else if (busy_ff)
            q_ff <= q_ff + 4'h1;
    end

    assign bus.scl_h_o = 1'b0;
    assign bus.scl_h_oe = scl_low_ff;
    assign bus.sda_h_o = 1'b0;
    assign bus.sda_h_oe = sda_low_ff;
endmodule

/* File: smb_props.sv */
// concurrent checks on the shared lines of the serial management link
`timescale 1ns/1ps
module smb_props
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_h_o,
    input wire logic scl_h_oe,
    input wire logic sda_h_o,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic alert_d_o,
    input wire logic alert_d_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic alert
);
    // ====================
    // line rules
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_free: assert property ($fell(rst) |-> !sda_d_oe && !alert_d_oe && !scl_h_oe)
        else $error("line driven after reset");
    a_open_drain: assert property (!sda_d_o && !alert_d_o && alert == !alert_d_oe)
        else $error("target drives a line high");
    a_host_drain: assert property (!scl_h_o && !sda_h_o)
        else $error("host drives a line high");
    // a target data change while the clock is high would read as start or stop
    a_ack_in_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("target data moved with clock high");
    a_alert_clear_ack: assert property ($fell(alert_d_oe) |-> scl && !sda_d_oe)
        else $error("alert dropped outside the answer ack");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_stop_idle: assert property ($rose(sda) && $past(scl) && scl |-> !sda_d_oe [*8])
        else $error("target drives after stop");
    c_alert_answer: cover property ($fell(alert_d_oe));
    c_target_ack: cover property ($rose(sda_d_oe));
    c_stop_seen: cover property ($rose(sda) && scl);
endmodule

/* File: tb_smbus_target_block_pec_alert.sv */
// bench joining host and target ends back to back over the shared lines
`timescale 1ns/1ps
`include "smb_consts.svh"
module tb_smbus_target_block_pec_alert
    import smb_pkg::*;
;
    typedef logic [19:0] step_t;
    localparam logic [2:0] STRAP = 3'h3;
    localparam logic [7:0] AW = {`ADDR_HI, STRAP, 1'b0};
    localparam logic [7:0] AR = {`ADDR_HI, STRAP, 1'b1};
    localparam step_t S = {OP_START, 18'h0};
    localparam step_t P = {OP_STOP, 18'h0};
    logic mclk, rst, temp_update, fault, monitor_tick, avs_read, avs_write, avs_waitrequest;
    logic [12:0] local_temp, remote_temp, fan_local_temp, fan_remote_temp;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_address;
    logic [2:0] address_select_input;
    logic [7:0] pec;
    int fails = 0;
    int checks_done = 0;
    logic [23:0] rows [5] = '{24'h055a5a, 24'h3fa5a5, 24'h02ffff, 24'h010000, 24'h000202};
    logic [28:0] locks [4] = '{{13'h1abc, 8'h40, 8'he0}, {13'h0123, 8'h41, 8'hd5}, {13'h0123, 8'h41, 8'h09},
        {13'h1abc, 8'h41, 8'hd5}};
    smb_if bus_if();
    smb_target #(.TIMEOUT_CYC(2000)) u_smb_target(.mclk(mclk), .rst(rst), .address_select_input(address_select_input),
        .local_temp(local_temp), .remote_temp(remote_temp), .temp_update(temp_update), .fault(fault),
        .monitor_tick(monitor_tick), .fan_local_temp(fan_local_temp), .fan_remote_temp(fan_remote_temp), .bus(bus_if));
    smb_host u_smb_host(.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus_if));
    smb_props u_smb_props(.mclk(mclk), .rst(rst), .scl_h_o(bus_if.scl_h_o), .scl_h_oe(bus_if.scl_h_oe),
        .sda_h_o(bus_if.sda_h_o), .sda_d_o(bus_if.sda_d_o), .sda_d_oe(bus_if.sda_d_oe), .alert_d_o(bus_if.alert_d_o),
        .alert_d_oe(bus_if.alert_d_oe), .scl(bus_if.scl), .sda(bus_if.sda), .alert(bus_if.alert));
    // ====================
    // tasks
    task automatic stop_test;
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            fails++;
            stop_test;
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 4000);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        tmo(n, 4000);
    endtask
    function automatic step_t w(input logic [7:0] b, input logic a = 1'b1);
        return {OP_WRITE, 1'b0, b, 1'b1, 7'h0, a};
    endfunction
    function automatic step_t r(input logic k, input logic [7:0] e);
        return {OP_READ, k, 8'h0, 1'b1, e};
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        for (int k = 0; k < 8; k++)
            x = {x[6:0], 1'b0} ^ (x[7] ? `CRC_POLY : 8'h00);
        return x;
    endfunction
    // one host op per step, status polled until the engine is idle
    task automatic run(input step_t s[$]);
        int n;
        foreach (s[i])
        begin
            av(1'b1, `HREG_CMD, {21'h0, s[i][17], s[i][19:18], s[i][16:9]});
            n = 0;
            do
            begin
                av(1'b0, `HREG_STAT, 32'h0);
                n++;
            end
            while (rd[8] !== 1'b0 && n < 200);
            tmo(n, 200);
            if (s[i][8])
                chk(32'((s[i][19:18] == OP_READ) ? rd[7:0] : {7'h0, rd[9]}), 32'(s[i][7:0]));
        end
    endtask
    task automatic rdreg(input logic [7:0] p, input logic [7:0] e);
        run({S, w(AW), w(p), P, S, w(AR), r(1'b1, e), P});
    endtask
    task automatic upd(input logic [12:0] t);
        @(posedge mclk);
        local_temp <= t;
        remote_temp <= ~t;
        temp_update <= 1'b1;
        @(posedge mclk);
        temp_update <= 1'b0;
        #1;
        chk(32'({fan_local_temp, fan_remote_temp}), 32'({t, ~t}));
    endtask
    // ====================
    // stimulus
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        {rst, temp_update, fault, monitor_tick, avs_read, avs_write} <= 6'h20;
        {address_select_input, local_temp, remote_temp, avs_address, avs_writedata} <= {STRAP, 62'h0};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk(32'({bus_if.scl, bus_if.sda, bus_if.alert, fan_local_temp}), 32'h0000e000);
        rdreg(8'h00, `BLK_LEN_RST);
        rdreg(8'h01, `CFG_ONE_RST);
        foreach (rows[i])
        begin
            run({S, w(AW), w(rows[i][23:16]), w(rows[i][15:8]), P});
            rdreg(rows[i][23:16], rows[i][7:0]);
        end
        run({S, w(AR ^ 8'h02, 1'b0), P, S, w({`ARA_ADDR, 1'b1}, 1'b0), P});
        run({S, w(AW), w(8'h85), w(8'h02), w(8'h11), w(8'h22), P});
        run({S, w(AW), w(8'h85), S, w(AR), r(1'b0, 8'h02), r(1'b0, 8'h11), r(1'b1, 8'h22), P});
        run({S, w(AW), w(8'h00), w(8'h28), P, S, w(AW), w(8'h85), S, w(AR), r(1'b1, `BLK_MAX), P});
        pec = crc8(crc8(8'h00, AR), 8'h11);
        run({S, w(AW), w(8'h05), P, S, w(AR), r(1'b0, 8'h11), r(1'b1, pec), P});
        run({S, w(AW), w(8'h07), w(8'h33), w(8'hab), w(8'hab, 1'b0), P});
        foreach (locks[i])
        begin
            upd(locks[i][28:16]);
            rdreg(locks[i][15:8], locks[i][7:0]);
        end
        {fault, monitor_tick} <= 2'h3;
        @(posedge mclk);
        monitor_tick <= 1'b0;
        run({S});
        chk(32'(rd[10]), 32'h1);
        run({w({`ARA_ADDR, 1'b1}), r(1'b1, AW), P});
        chk(32'(bus_if.alert), 32'h1);
        monitor_tick <= 1'b1;
        @(posedge mclk);
        monitor_tick <= 1'b0;
        @(posedge mclk);
        #1;
        chk(32'(bus_if.alert), 32'h0);
        stop_test;
    end
endmodule
